// ==== hdl/lmmso_core.sv ====
// Purpose: executes literal, move, multiply, negate and stack instructions
// Assumes: fetch, data memory and return stack share SYS_CLK_IN;
//          data memory answers a read in the same cycle it is requested
// Notes:   one instruction cycle is four clock cycles, Q1 to Q4
`default_nettype none

// Notes on behaviour
// RULE_01 - load literal into accumulator, flags kept
// RULE_02 - store accumulator to file, flags kept
// RULE_03 - bank bit picks access or selected bank
// RULE_04 - indexed mode: bit zero, extended, f<=5Fh
// RULE_05 - file field spans whole 256-byte bank
// RULE_06 - literal multiply, high byte upper, accumulator kept
// RULE_07 - file multiply into product pair, operands kept
// RULE_08 - multiplies never touch status flags
// RULE_09 - negate file, update five flags
// RULE_10 - pop discards top entry, one cycle
// RULE_11 - push PC plus two, one cycle
// RULE_12 - relative call pushes, jumps PC+2+2n
// RULE_13 - relative call takes two cycles
// RULE_14 - decode, read, process, write per quarter
module lmmso_core #(
  parameter int PC_W = lmmso_pkg::PC_W
) (
  input  wire logic                             SYS_CLK_IN,
  input  wire logic                             RST_B_IN,
  input  wire logic [lmmso_pkg::INSTR_W-1:0]    INSTR_IN,
  input  wire logic                             INSTR_VALID_IN,
  input  wire logic [PC_W-1:0]                  PC_IN,
  input  wire logic [lmmso_pkg::BANK_W-1:0]     BANK_SEL_IN,
  input  wire logic                             EXT_SET_EN_IN,
  input  wire logic [7:0]                       DMEM_RDATA_IN,
  output logic                                  INSTR_READY_OUT,
  output logic      [1:0]                       PHASE_OUT,
  output lmmso_pkg::lmmso_dmem_req_t            DMEM_REQ_OUT,
  output lmmso_pkg::lmmso_stack_req_t           STACK_REQ_OUT,
  output logic                                  PC_LOAD_OUT,
  output logic      [PC_W-1:0]                  PC_NEW_OUT,
  output logic      [7:0]                       ACC_OUT,
  output logic      [7:0]                       PROD_HIGH_OUT,
  output logic      [7:0]                       PROD_LOW_OUT,
  output lmmso_pkg::lmmso_status_t              STATUS_OUT,
  output logic                                  INDEXED_MODE_OUT
);

  // the stack entry width is fixed by the package, and the call target
  // needs room above the doubled offset; refuse anything else
  if (PC_W != lmmso_pkg::PC_W) begin : g_pc_width_check
    $error("lmmso_core: PC_W must match the stack entry width");
  end
  if (PC_W <= lmmso_pkg::OFFSET_W + 1) begin : g_pc_room_check
    $error("lmmso_core: PC_W too narrow for the call offset");
  end

  // extended-set enable is a configuration pin: two-stage synchroniser
  logic ext_meta_reg;
  logic ext_sync_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= EXT_SET_EN_IN;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // address resolution from the incoming word, latched at end of Q1
  logic [lmmso_pkg::DADDR_W-1:0] res_addr;
  logic                          res_indexed;

  lmmso_addr_resolve u_addr_resolve (
    .file_addr_in  (INSTR_IN[7:0]),
    .bank_mode_in  (INSTR_IN[lmmso_pkg::BANK_MODE_BIT]),
    .bank_sel_in   (BANK_SEL_IN),
    .ext_set_en_in (ext_sync_reg),
    .data_addr_out (res_addr),
    .indexed_out   (res_indexed)
  );

  // decode of the incoming word
  lmmso_pkg::lmmso_op_t dec_op;

  function automatic logic op_match(input logic [15:0] word,
                                    input logic [15:0] mask,
                                    input logic [15:0] pat);
    op_match = ((word & mask) == pat);
  endfunction : op_match

  // first match wins; the patterns here never overlap
  always_comb begin
    dec_op = lmmso_pkg::OP_NONE;
    if (op_match(INSTR_IN, lmmso_pkg::MASK_BYTE, lmmso_pkg::PAT_LOAD_LIT)) begin
      dec_op = lmmso_pkg::OP_LOAD_LIT; // RULE_01
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_FILE,
                          lmmso_pkg::PAT_STORE_ACC)) begin
      dec_op = lmmso_pkg::OP_STORE_ACC; // RULE_02
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_BYTE,
                          lmmso_pkg::PAT_MUL_LIT)) begin
      dec_op = lmmso_pkg::OP_MUL_LIT; // RULE_06
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_FILE,
                          lmmso_pkg::PAT_MUL_FILE)) begin
      dec_op = lmmso_pkg::OP_MUL_FILE; // RULE_07
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_FILE,
                          lmmso_pkg::PAT_NEGATE)) begin
      dec_op = lmmso_pkg::OP_NEGATE; // RULE_09
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_FULL,
                          lmmso_pkg::PAT_POP)) begin
      dec_op = lmmso_pkg::OP_POP; // RULE_10
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_FULL,
                          lmmso_pkg::PAT_PUSH)) begin
      dec_op = lmmso_pkg::OP_PUSH; // RULE_11
    end else if (op_match(INSTR_IN, lmmso_pkg::MASK_CALL,
                          lmmso_pkg::PAT_REL_CALL)) begin
      dec_op = lmmso_pkg::OP_REL_CALL; // RULE_12
    end
  end

  // sequencer and datapath state
  lmmso_pkg::lmmso_phase_t  phase_reg,   phase_next;
  logic                     hold_reg,    hold_next;
  lmmso_pkg::lmmso_op_t     op_reg,      op_next;
  logic [15:0]              instr_reg,   instr_next;
  logic [PC_W-1:0]          pc_reg,      pc_next;
  logic [lmmso_pkg::DADDR_W-1:0] addr_reg, addr_next;
  logic                     indexed_reg, indexed_next;
  logic [7:0]               operand_reg, operand_next;
  logic [15:0]              result_reg,  result_next;
  logic [PC_W-1:0]          ret_reg,     ret_next;
  logic [PC_W-1:0]          target_reg,  target_next;
  lmmso_pkg::lmmso_status_t flag_calc_reg, flag_calc_next;
  logic [7:0]               acc_reg,     acc_next;
  logic [15:0]              prod_reg,    prod_next;
  lmmso_pkg::lmmso_status_t status_reg,  status_next;

  // return address step, sized once to the counter width
  localparam logic [PC_W-1:0] PC_STEP_W = PC_W'(lmmso_pkg::PC_STEP);

  // negate arithmetic: carry out of ~f + 1 and of its low nibble
  logic [8:0]      neg_sum;
  logic [4:0]      neg_nib;
  logic [PC_W-1:0] off_ext;
  logic [15:0]     mul_prod;

  // both factors widened first so the full 16-bit product survives
  always_comb begin
    neg_sum = {1'b0, ~operand_reg} + 9'h001; // RULE_09
    neg_nib = {1'b0, ~operand_reg[3:0]} + 5'h01;
    off_ext = PC_W'($signed({instr_reg[lmmso_pkg::OFF_MSB:0], 1'b0}));
    mul_prod = 16'(acc_reg) * 16'(operand_reg); // RULE_06
  end

  always_comb begin
    phase_next     = phase_reg;
    hold_next      = hold_reg;
    op_next        = op_reg;
    instr_next     = instr_reg;
    pc_next        = pc_reg;
    addr_next      = addr_reg;
    indexed_next   = indexed_reg;
    operand_next   = operand_reg;
    result_next    = result_reg;
    ret_next       = ret_reg;
    target_next    = target_reg;
    flag_calc_next = flag_calc_reg;
    acc_next       = acc_reg;
    prod_next      = prod_reg;
    status_next    = status_reg;
    case (phase_reg)
      lmmso_pkg::PH_Q1: begin
        phase_next = lmmso_pkg::PH_Q2;
        // decode quarter; idle second call cycle takes no word
        if (INSTR_VALID_IN && !hold_reg) begin // RULE_14
          op_next      = dec_op;
          instr_next   = INSTR_IN;
          pc_next      = PC_IN;
          addr_next    = res_addr;
          indexed_next = res_indexed;
        end else begin
          op_next      = lmmso_pkg::OP_NONE;
          indexed_next = 1'b0;
        end
      end
      lmmso_pkg::PH_Q2: begin
        phase_next = lmmso_pkg::PH_Q3;
        case (op_reg) // RULE_14
          lmmso_pkg::OP_MUL_FILE,
          lmmso_pkg::OP_NEGATE:    operand_next = DMEM_RDATA_IN;
          lmmso_pkg::OP_STORE_ACC: operand_next = acc_reg;
          default:                 operand_next = instr_reg[7:0];
        endcase
      end
      lmmso_pkg::PH_Q3: begin
        phase_next = lmmso_pkg::PH_Q4;
        ret_next   = pc_reg + PC_STEP_W; // RULE_11
        target_next = pc_reg + PC_STEP_W + off_ext; // RULE_12
        case (op_reg)
          lmmso_pkg::OP_MUL_LIT,
          lmmso_pkg::OP_MUL_FILE: begin
            result_next = mul_prod; // RULE_06 RULE_07
          end
          lmmso_pkg::OP_NEGATE: begin
            result_next = {8'h00, neg_sum[7:0]};
            flag_calc_next.negative     = neg_sum[7];
            flag_calc_next.zero         = (neg_sum[7:0] == 8'h00);
            flag_calc_next.carry        = neg_sum[8];
            flag_calc_next.half_carry   = neg_nib[4];
            // only 80h keeps its sign bit after negation
            flag_calc_next.signed_range = operand_reg[7] & neg_sum[7];
          end
          default: result_next = {8'h00, operand_reg};
        endcase
      end
      lmmso_pkg::PH_Q4: begin
        phase_next = lmmso_pkg::PH_Q1;
        case (op_reg) // RULE_14
          lmmso_pkg::OP_LOAD_LIT: acc_next = result_reg[7:0]; // RULE_01
          lmmso_pkg::OP_MUL_LIT,
          lmmso_pkg::OP_MUL_FILE: prod_next = result_reg; // RULE_08
          lmmso_pkg::OP_NEGATE:   status_next = flag_calc_reg; // RULE_09
          default: ;
        endcase
        // call occupies a second, empty instruction cycle
        hold_next = (op_reg == lmmso_pkg::OP_REL_CALL); // RULE_13
      end
      default: phase_next = lmmso_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      phase_reg     <= lmmso_pkg::PH_Q1;
      hold_reg      <= 1'b0;
      op_reg        <= lmmso_pkg::OP_NONE;
      instr_reg     <= 16'h0000;
      pc_reg        <= '0;
      addr_reg      <= '0;
      indexed_reg   <= 1'b0;
      operand_reg   <= 8'h00;
      result_reg    <= 16'h0000;
      ret_reg       <= '0;
      target_reg    <= '0;
      flag_calc_reg <= lmmso_pkg::STATUS_RESET;
      acc_reg       <= lmmso_pkg::ACC_RESET;
      prod_reg      <= lmmso_pkg::PROD_RESET;
      status_reg    <= lmmso_pkg::STATUS_RESET;
    end else begin
      phase_reg     <= phase_next;
      hold_reg      <= hold_next;
      op_reg        <= op_next;
      instr_reg     <= instr_next;
      pc_reg        <= pc_next;
      addr_reg      <= addr_next;
      indexed_reg   <= indexed_next;
      operand_reg   <= operand_next;
      result_reg    <= result_next;
      ret_reg       <= ret_next;
      target_reg    <= target_next;
      flag_calc_reg <= flag_calc_next;
      acc_reg       <= acc_next;
      prod_reg      <= prod_next;
      status_reg    <= status_next;
    end
  end

  // strobes are combinational from registered state; data from flops
  logic in_q2;
  logic in_q4;
  logic reads_file;
  logic writes_file;
  logic pushes_pc;

  always_comb begin
    in_q2 = (phase_reg == lmmso_pkg::PH_Q2);
    in_q4 = (phase_reg == lmmso_pkg::PH_Q4);
    reads_file  = (op_reg == lmmso_pkg::OP_MUL_FILE) ||
                  (op_reg == lmmso_pkg::OP_NEGATE);
    writes_file = (op_reg == lmmso_pkg::OP_STORE_ACC) ||
                  (op_reg == lmmso_pkg::OP_NEGATE);
    // a call pushes its return address like a plain push
    pushes_pc   = (op_reg == lmmso_pkg::OP_PUSH) ||
                  (op_reg == lmmso_pkg::OP_REL_CALL);
    INSTR_READY_OUT = (phase_reg == lmmso_pkg::PH_Q1) && !hold_reg;
    PHASE_OUT       = phase_reg;
    DMEM_REQ_OUT.rd = in_q2 && reads_file; // RULE_07
    DMEM_REQ_OUT.wr = in_q4 && writes_file; // RULE_02
    DMEM_REQ_OUT.addr  = addr_reg; // RULE_03
    DMEM_REQ_OUT.wdata = result_reg[7:0];
    STACK_REQ_OUT.push = in_q4 && pushes_pc; // RULE_12
    STACK_REQ_OUT.pop  = in_q4 && (op_reg == lmmso_pkg::OP_POP); // RULE_10
    STACK_REQ_OUT.push_data = ret_reg;
    PC_LOAD_OUT     = in_q4 && (op_reg == lmmso_pkg::OP_REL_CALL); // RULE_12
    PC_NEW_OUT      = target_reg;
    ACC_OUT         = acc_reg;
    PROD_HIGH_OUT   = prod_reg[15:8]; // RULE_06
    PROD_LOW_OUT    = prod_reg[7:0];
    STATUS_OUT      = status_reg;
    INDEXED_MODE_OUT = indexed_reg; // RULE_04
  end

endmodule : lmmso_core

`default_nettype wire

// ==== hdl/lmmso_pkg.sv ====
// Purpose: shared constants and types of the instruction execution block
// Assumes: 16-bit instruction words, 14-bit data space, 21-bit program counter
// Notes:   opcodes are matched under the masks kept beside them
`default_nettype none

package lmmso_pkg;

  localparam int INSTR_W   = 16;
  localparam int DADDR_W   = 14;
  localparam int BANK_W    = 6;
  localparam int FADDR_W   = 8;
  localparam int PC_W      = 21;
  localparam int OFFSET_W  = 11;

  // opcode patterns and the bits they compare
  localparam logic [15:0] MASK_BYTE      = 16'hFF00;
  localparam logic [15:0] MASK_FILE      = 16'hFE00;
  localparam logic [15:0] MASK_FULL      = 16'hFFFF;
  localparam logic [15:0] MASK_CALL      = 16'hF800;
  localparam logic [15:0] PAT_LOAD_LIT   = 16'h0E00;
  localparam logic [15:0] PAT_STORE_ACC  = 16'h6E00;
  localparam logic [15:0] PAT_MUL_LIT    = 16'h0D00;
  localparam logic [15:0] PAT_MUL_FILE   = 16'h0200;
  localparam logic [15:0] PAT_NEGATE     = 16'h6C00;
  localparam logic [15:0] PAT_POP        = 16'h0006;
  localparam logic [15:0] PAT_PUSH       = 16'h0005;
  localparam logic [15:0] PAT_REL_CALL   = 16'hD800;

  // instruction field positions
  localparam int BANK_MODE_BIT = 8;
  localparam int LIT_LSB       = 0;
  localparam int OFF_MSB       = 10;

  // addressing constants
  localparam logic [7:0] INDEXED_LIMIT   = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
  localparam logic [5:0] ACCESS_LO_BANK  = 6'h00;
  localparam logic [5:0] ACCESS_HI_BANK  = 6'h3F;

  localparam logic [20:0] PC_STEP        = 21'h000002;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [15:0] PROD_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } lmmso_phase_t;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_LOAD_LIT     = 4'h1,
    OP_STORE_ACC    = 4'h2,
    OP_MUL_LIT      = 4'h3,
    OP_MUL_FILE     = 4'h4,
    OP_NEGATE       = 4'h5,
    OP_POP          = 4'h6,
    OP_PUSH         = 4'h7,
    OP_REL_CALL     = 4'h8
  } lmmso_op_t;

  typedef struct packed {
    logic negative;
    logic signed_range;
    logic zero;
    logic half_carry;
    logic carry;
  } lmmso_status_t;

  localparam lmmso_status_t STATUS_RESET = 5'h00;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [DADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } lmmso_dmem_req_t;

  typedef struct packed {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] push_data;
  } lmmso_stack_req_t;

endpackage : lmmso_pkg

`default_nettype wire

// ==== hdl/lmmso_addr_resolve.sv ====
// Purpose: turns the 8-bit file field and bank-mode bit into a data address
// Assumes: bank select value and extended-set enable are stable in Q1
// Notes:   indexed mode is only flagged; offset arithmetic lives elsewhere
`default_nettype none

module lmmso_addr_resolve (
  input  wire logic [7:0]                   file_addr_in,
  input  wire logic                         bank_mode_in,
  input  wire logic [lmmso_pkg::BANK_W-1:0] bank_sel_in,
  input  wire logic                         ext_set_en_in,
  output logic      [lmmso_pkg::DADDR_W-1:0] data_addr_out,
  output logic                              indexed_out
);

  logic [lmmso_pkg::BANK_W-1:0] bank;

  always_comb begin
    if (bank_mode_in) begin
      bank = bank_sel_in; // RULE_03
    end else if (file_addr_in < lmmso_pkg::ACCESS_SPLIT) begin
      bank = lmmso_pkg::ACCESS_LO_BANK; // RULE_03
    end else begin
      bank = lmmso_pkg::ACCESS_HI_BANK;
    end
    data_addr_out = {bank, file_addr_in}; // RULE_05
    indexed_out   = !bank_mode_in && ext_set_en_in &&
                    (file_addr_in <= lmmso_pkg::INDEXED_LIMIT); // RULE_04
  end

endmodule : lmmso_addr_resolve

`default_nettype wire

// ==== tb/lmmso_core_assertions.sv ====
// Purpose: port timing checks of the execution block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the core from the bench top
`default_nettype none
module lmmso_core_assertions #(
  parameter int PC_W = lmmso_pkg::PC_W
) (
  input wire logic                        SYS_CLK_IN,
  input wire logic                        RST_B_IN,
  input wire logic [15:0]                 INSTR_IN,
  input wire logic [PC_W-1:0]             PC_IN,
  input wire logic                        INSTR_READY_OUT,
  input wire logic [1:0]                  PHASE_OUT,
  input wire lmmso_pkg::lmmso_dmem_req_t  DMEM_REQ_OUT,
  input wire lmmso_pkg::lmmso_stack_req_t STACK_REQ_OUT,
  input wire logic                        PC_LOAD_OUT,
  input wire logic [PC_W-1:0]             PC_NEW_OUT,
  input wire logic [7:0]                  ACC_OUT,
  input wire logic [7:0]                  PROD_HIGH_OUT,
  input wire logic [7:0]                  PROD_LOW_OUT,
  input wire lmmso_pkg::lmmso_status_t    STATUS_OUT
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence seq_quarters;
    PHASE_OUT == 2'h1 ##1 PHASE_OUT == 2'h3 ##1 PHASE_OUT == 2'h2
      ##1 PHASE_OUT == 2'h0;
  endsequence
  sequence seq_call_gap;
    !INSTR_READY_OUT ##4 INSTR_READY_OUT;
  endsequence
  chk_quarter_order: assert property (
    PHASE_OUT == 2'h0 |=> seq_quarters) else $error("phase order broken");
  chk_read_slot: assert property (
    DMEM_REQ_OUT.rd |-> PHASE_OUT == 2'h1) else $error("read off slot");
  chk_write_slot: assert property (
    DMEM_REQ_OUT.wr |-> PHASE_OUT == 2'h2) else $error("write off slot");
  chk_stack_slot: assert property (
    STACK_REQ_OUT.pop |-> PHASE_OUT == 2'h2 && !STACK_REQ_OUT.push)
    else $error("pop misplaced");
  chk_push_value: assert property (
    STACK_REQ_OUT.push |-> PHASE_OUT == 2'h2
      && STACK_REQ_OUT.push_data == $past(PC_IN, 3) + PC_W'(2))
    else $error("pushed address wrong");
  chk_call_target: assert property (
    PC_LOAD_OUT |-> STACK_REQ_OUT.push && PC_NEW_OUT == $past(PC_IN, 3)
      + PC_W'(2) + {{(PC_W-12){$past(INSTR_IN[10], 3)}},
      $past(INSTR_IN[10:0], 3), 1'b0})
    else $error("call target wrong");
  chk_call_gap: assert property (
    PC_LOAD_OUT |=> seq_call_gap) else $error("call gap wrong");
  chk_mul_flags: assert property (
    $changed({PROD_HIGH_OUT, PROD_LOW_OUT})
      |-> $stable(STATUS_OUT) && $stable(ACC_OUT))
    else $error("multiply touched flags or accumulator");
  chk_neg_flags: assert property (
    DMEM_REQ_OUT.wr && $past(DMEM_REQ_OUT.rd, 2) |=>
      STATUS_OUT.zero == ($past(DMEM_REQ_OUT.wdata) == 8'h00)
      && STATUS_OUT.carry == STATUS_OUT.zero
      && STATUS_OUT.negative == $past(DMEM_REQ_OUT.wdata[7]))
    else $error("negate flags wrong");
  chk_store_flags: assert property (
    DMEM_REQ_OUT.wr && !$past(DMEM_REQ_OUT.rd, 2) |=> $stable(STATUS_OUT))
    else $error("store changed flags");
  chk_acc_slot: assert property (
    $changed(ACC_OUT) |-> $past(PHASE_OUT) == 2'h2)
    else $error("accumulator written off slot");
endmodule : lmmso_core_assertions
`default_nettype wire

// ==== tb/lmmso_far_model.sv ====
// Purpose: data memory and return stack beside the execution block
// Assumes: a read is answered in the cycle that asks for it
// Notes:   idle read lines show the inverse of the last value read
`default_nettype none
module lmmso_far_model (
  input  wire logic                        clk_in,
  input  wire lmmso_pkg::lmmso_dmem_req_t  dmem_req_in,
  input  wire lmmso_pkg::lmmso_stack_req_t stack_req_in,
  output logic      [7:0]                  rdata_out,
  output logic      [20:0]                 tos_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:16383];
  logic [7:0]  last_q = 8'h5A;
  logic [20:0] stk [$];
  // undriven reads must not look like a plausible stale value
  always_comb begin
    rdata_out = dmem_req_in.rd ? mem[dmem_req_in.addr] : ~last_q;
  end
  always @(posedge clk_in) begin
    if (dmem_req_in.rd) last_q <= mem[dmem_req_in.addr];
    if (dmem_req_in.wr) mem[dmem_req_in.addr] <= dmem_req_in.wdata;
    if (stack_req_in.push) stk.push_front(stack_req_in.push_data);
    if (stack_req_in.pop && stk.size() > 0) void'(stk.pop_front());
    tos_out = stk.size() > 0 ? stk[0] : 21'h1FFFFF;
  end
endmodule : lmmso_far_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the execution block
// Assumes: inputs change on the falling clock edge
// Notes:   driver queues expectations, monitor checks them per slot
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC_W = 21;
  typedef struct {
    logic        rd, wr, push, pop, load, idx;
    logic [13:0] addr;
    logic [7:0]  wdata, acc, ph, pl;
    logic [20:0] pdata, pnew, top_of_stack_entry;
    logic [4:0]  st;
  } lmmso_note_t;
  logic        SYS_CLK_IN = 1'b0;
  logic        RST_B_IN = 1'b0;
  logic        INSTR_VALID_IN = 1'b0;
  logic        EXT_SET_EN_IN = 1'b0;
  logic [15:0] INSTR_IN = 16'h0000;
  logic [20:0] PC_IN = 21'h000000;
  logic [5:0]  BANK_SEL_IN = 6'h00;
  logic [7:0]  DMEM_RDATA_IN, ACC_OUT, PROD_HIGH_OUT, PROD_LOW_OUT;
  logic        INSTR_READY_OUT, PC_LOAD_OUT, INDEXED_MODE_OUT;
  logic [1:0]  PHASE_OUT;
  logic [20:0] PC_NEW_OUT, top_of_stack_entry;
  lmmso_pkg::lmmso_dmem_req_t  DMEM_REQ_OUT;
  lmmso_pkg::lmmso_stack_req_t STACK_REQ_OUT;
  lmmso_pkg::lmmso_status_t    STATUS_OUT;
  int          bad_count = 0;
  int          checks_done = 0;
  logic        due = 1'b0;
  lmmso_note_t notes [$];
  lmmso_note_t nt, cur, last;
  logic [20:0] stk [$];
  logic [31:0] rnd = 32'h0001673E;
  logic [7:0]  acc_m = 8'h00, ph_m = 8'h00, pl_m = 8'h00;
  logic [4:0]  st_m = 5'h00;

  always #2 SYS_CLK_IN = ~SYS_CLK_IN;

  lmmso_core #(.PC_W(PC_W)) dut (.SYS_CLK_IN(SYS_CLK_IN),
    .RST_B_IN(RST_B_IN), .INSTR_IN(INSTR_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN), .PC_IN(PC_IN),
    .BANK_SEL_IN(BANK_SEL_IN), .EXT_SET_EN_IN(EXT_SET_EN_IN),
    .DMEM_RDATA_IN(DMEM_RDATA_IN), .INSTR_READY_OUT(INSTR_READY_OUT),
    .PHASE_OUT(PHASE_OUT), .DMEM_REQ_OUT(DMEM_REQ_OUT),
    .STACK_REQ_OUT(STACK_REQ_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
    .PC_NEW_OUT(PC_NEW_OUT), .ACC_OUT(ACC_OUT),
    .PROD_HIGH_OUT(PROD_HIGH_OUT), .PROD_LOW_OUT(PROD_LOW_OUT),
    .STATUS_OUT(STATUS_OUT), .INDEXED_MODE_OUT(INDEXED_MODE_OUT));
  lmmso_far_model far (.clk_in(SYS_CLK_IN), .dmem_req_in(DMEM_REQ_OUT),
    .stack_req_in(STACK_REQ_OUT), .rdata_out(DMEM_RDATA_IN),
    .tos_out(top_of_stack_entry));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // after a call the next word is left valid to prove it is refused
  task automatic issue(input logic [15:0] w, input logic [7:0] mv,
                       input logic hold);
    int k;
    k = 0;
    do begin
      @(negedge SYS_CLK_IN);
      k++;
    end while (!(PHASE_OUT === 2'h0 && INSTR_READY_OUT === 1'b1) && k < 12);
    check(k < 12, 1'b1);
    far.mem[nt.addr] = mv;
    INSTR_IN = w;
    INSTR_VALID_IN = 1'b1;
    notes.push_back(nt);
    @(negedge SYS_CLK_IN);
    INSTR_VALID_IN = hold;
    if (hold) INSTR_IN = 16'h0005;
  endtask : issue

  always @(negedge SYS_CLK_IN) begin
    cur = '{default: '0};
    if (notes.size() > 0) cur = notes[0];
    if (RST_B_IN && PHASE_OUT === 2'h1) begin
      check(DMEM_REQ_OUT.rd, cur.rd);
      if (cur.rd) check(DMEM_REQ_OUT.addr, cur.addr);
      if (cur.rd | cur.wr) check(INDEXED_MODE_OUT, cur.idx);
    end
    if (RST_B_IN && PHASE_OUT === 2'h2) begin
      check(DMEM_REQ_OUT.wr, cur.wr);
      if (cur.wr) check(DMEM_REQ_OUT.addr, cur.addr);
      if (cur.wr) check(DMEM_REQ_OUT.wdata, cur.wdata);
      check(STACK_REQ_OUT.pop, cur.pop);
      check(STACK_REQ_OUT.push, cur.push);
      if (cur.push) check(STACK_REQ_OUT.push_data, cur.pdata);
      check(PC_LOAD_OUT, cur.load);
      if (cur.load) check(PC_NEW_OUT, cur.pnew);
      if (notes.size() > 0) last = notes.pop_front();
      due = notes.size() == 0 && cur.wdata !== 8'hXX;
    end else if (RST_B_IN && due) begin
      due = 1'b0;
      check({ACC_OUT, PROD_HIGH_OUT, PROD_LOW_OUT},
            {last.acc, last.ph, last.pl});
      check(STATUS_OUT, last.st);
      check(top_of_stack_entry, last.top_of_stack_entry);
    end
  end

  initial begin
    logic [31:0] r2;
    logic [7:0]  f, lit, mv, neg;
    logic [10:0] off;
    logic [15:0] w;
    logic        a;
    int          k;
    last = '{default: '0};
    last.top_of_stack_entry = 21'h1FFFFF;
    repeat (8) @(posedge SYS_CLK_IN);
    @(negedge SYS_CLK_IN);
    RST_B_IN = 1'b1;
    for (int i = 0; i < 90; i++) begin
      rnd = lfsr(rnd);
      r2 = lfsr(rnd ^ 32'h00C3A5F0);
      k = i % 9;
      f = (i == 1) ? 8'h5F : (i == 10) ? 8'h60 : rnd[7:0];
      lit = (i == 0) ? 8'hE2 : (i == 2) ? 8'hC4 : rnd[15:8];
      mv = (i == 4) ? 8'h00 : (i == 13) ? 8'h80 : r2[7:0];
      off = (i == 7) ? 11'h400 : (i == 16) ? 11'h3FF : r2[18:8];
      neg = 8'h00 - mv;
      a = rnd[16];
      BANK_SEL_IN = rnd[22:17];
      PC_IN = {r2[31:12], 1'b0};
      nt = '{default: '0};
      nt.addr = a ? {BANK_SEL_IN, f}
                  : {f < 8'h60 ? 6'h00 : 6'h3F, f};
      nt.idx = !a && EXT_SET_EN_IN && f <= 8'h5F;
      case (k)
        0: w = {8'h0E, lit};
        1: w = {7'h37, a, f};
        2: w = {8'h0D, lit};
        3: w = {7'h01, a, f};
        4: w = {7'h36, a, f};
        5: w = 16'h0005;
        6: w = 16'h0006;
        7: w = {5'h1B, off};
        default: w = 16'h0000;
      endcase
      {nt.rd, nt.wr} = {k == 3 || k == 4, k == 1 || k == 4};
      {nt.push, nt.pop, nt.load} = {k == 5 || k == 7, k == 6, k == 7};
      if (k == 0) acc_m = lit;
      if (k == 2 || k == 3) {ph_m, pl_m} = acc_m * (k == 2 ? lit : mv);
      if (k == 4) st_m = {neg[7], mv == 8'h80, neg == 8'h00,
                          mv[3:0] == 4'h0, mv == 8'h00};
      nt.wdata = k == 4 ? neg : acc_m;
      nt.pdata = PC_IN + 21'h000002;
      nt.pnew = nt.pdata + {{9{off[10]}}, off, 1'b0};
      if (nt.push) stk.push_front(nt.pdata);
      if (nt.pop && stk.size() > 0) void'(stk.pop_front());
      nt.top_of_stack_entry = stk.size() > 0 ? stk[0] : 21'h1FFFFF;
      {nt.acc, nt.ph, nt.pl, nt.st} = {acc_m, ph_m, pl_m, st_m};
      issue(w, mv, k == 7);
      EXT_SET_EN_IN = r2[31];
    end
    repeat (12) @(negedge SYS_CLK_IN);
    final_report();
  end

  initial begin
    #8000;
    bad_count++;
    final_report();
  end
endmodule : tb_top

bind lmmso_core lmmso_core_assertions #(.PC_W(PC_W)) chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .INSTR_IN(INSTR_IN),
  .PC_IN(PC_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .PHASE_OUT(PHASE_OUT),
  .DMEM_REQ_OUT(DMEM_REQ_OUT), .STACK_REQ_OUT(STACK_REQ_OUT),
  .PC_LOAD_OUT(PC_LOAD_OUT), .PC_NEW_OUT(PC_NEW_OUT), .ACC_OUT(ACC_OUT),
  .PROD_HIGH_OUT(PROD_HIGH_OUT), .PROD_LOW_OUT(PROD_LOW_OUT),
  .STATUS_OUT(STATUS_OUT));
`default_nettype wire
